// file: pkg/dmtm_regs.svh
// Constants for the transfer mode controller
`ifndef DMTM_REGS_SVH
`define DMTM_REGS_SVH

`define DMTM_MODE_STOP      3'h0
`define DMTM_MODE_BASIC     3'h1
`define DMTM_MODE_AUTO      3'h2
`define DMTM_MODE_PING_PONG 3'h3
`define DMTM_MODE_MEM_SG    3'h4

`define DMTM_COUNT_W        10
`define DMTM_COUNT_RST      10'h000
`define DMTM_ALT_RST        1'b0
`define DMTM_STOPPED_RST    1'b1

`endif

// file: pkg/dmtm_pkg.sv
// Types for the transfer mode controller
package dmtm_pkg;

  typedef struct packed {
    logic [9:0] item_count_minus_one;
    logic       spare_bit;
    logic [2:0] transfer_mode_field;
  } dmtm_ctl_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT_REQ,
    ST_ARB,
    ST_XFER,
    ST_SG
  } dmtm_state_t;

endpackage

// file: design/dmtm_item_counter.sv
// Outstanding item counter
`timescale 1ns/1ns
`include "dmtm_regs.svh"
module dmtm_item_counter
  import dmtm_pkg::*;
#(
  parameter int W = `DMTM_COUNT_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  output logic      [W-1:0] count,
  output logic              last
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign count_next = load ? load_val : (dec ? count_reg - W'(1) : count_reg);
  assign count      = count_reg;
  assign last       = (count_reg == '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= W'(`DMTM_COUNT_RST);
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// file: design/dmtm_mode_ctrl.sv
// Per-channel transfer mode controller
`timescale 1ns/1ns
`include "dmtm_regs.svh"
module dmtm_mode_ctrl
  import dmtm_pkg::*;
#(
  parameter int CW = `DMTM_COUNT_W
) (
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           chan_enable,
  input  wire logic           chan_request,
  output logic                fetch_req,
  output logic                fetch_alt,
  input  wire logic           fetch_valid,
  input  wire dmtm_ctl_word_t fetch_word,
  output logic                wb_valid,
  output dmtm_ctl_word_t      wb_word,
  output logic                xfer_pulse,
  output logic                cycle_done,
  output logic                chan_stopped,
  output logic                invalid_cfg,
  output logic                sg_start,
  input  wire logic           sg_done
);

  dmtm_state_t    state_reg;
  dmtm_state_t    state_next;
  logic [2:0]     mode_reg;
  logic [2:0]     mode_next;
  dmtm_ctl_word_t word_reg;
  dmtm_ctl_word_t word_next;
  logic           pend_req_reg;
  logic           pend_req_next;
  logic           alt_reg;
  logic           alt_next;
  logic           fetch_req_reg;
  logic           fetch_req_next;
  logic           wb_valid_reg;
  logic           wb_valid_next;
  dmtm_ctl_word_t wb_word_reg;
  dmtm_ctl_word_t wb_word_next;
  logic           xfer_reg;
  logic           xfer_next;
  logic           done_reg;
  logic           done_next;
  logic           stopped_reg;
  logic           stopped_next;
  logic           invalid_reg;
  logic           invalid_next;
  logic           sg_start_reg;
  logic           sg_start_next;
  logic [CW-1:0]  count;
  logic           last;
  logic           cnt_load;
  logic           cnt_dec;
  logic           fetched;
  logic [2:0]     fmode;
  logic           f_stop;
  logic           f_run;
  logic           f_sg;
  logic           req_take;

  assign fetched  = (state_reg == ST_FETCH) && fetch_valid;
  assign fmode    = fetch_word.transfer_mode_field;
  assign f_stop   = (fmode == `DMTM_MODE_STOP) || (fmode > `DMTM_MODE_MEM_SG);
  assign f_sg     = (fmode == `DMTM_MODE_MEM_SG);
  assign f_run    = !f_stop && !f_sg;
  assign req_take = (state_reg == ST_WAIT_REQ) && pend_req_reg;
  assign cnt_load = fetched && f_run;
  assign cnt_dec  = (state_reg == ST_XFER) && !last;

  // Pending request: a new request wins over its own consumption
  assign pend_req_next = chan_request || (pend_req_reg && !req_take);

  dmtm_item_counter #(
    .W (CW)
  ) u_count (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (cnt_load),
    .load_val (fetch_word.item_count_minus_one),
    .dec      (cnt_dec),
    .count    (count),
    .last     (last)
  );

  always_comb begin
    state_next     = state_reg;
    mode_next      = mode_reg;
    word_next      = word_reg;
    alt_next       = alt_reg;
    fetch_req_next = 1'b0;
    wb_valid_next  = 1'b0;
    wb_word_next   = wb_word_reg;
    xfer_next      = 1'b0;
    done_next      = 1'b0;
    stopped_next   = stopped_reg;
    invalid_next   = 1'b0;
    sg_start_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (chan_enable) begin
          state_next     = ST_FETCH;
          fetch_req_next = 1'b1;
          stopped_next   = 1'b0;
        end
      end
      ST_FETCH: begin
        fetch_req_next = 1'b1;
        if (fetch_valid) begin
          fetch_req_next = 1'b0;
          mode_next      = fmode;
          word_next      = fetch_word;
          if (f_stop) begin
            state_next   = ST_IDLE;
            stopped_next = 1'b1;
            invalid_next = 1'b1;
          end else if (f_sg) begin
            state_next    = ST_SG;
            sg_start_next = 1'b1;
          end else begin
            state_next = ST_WAIT_REQ;
          end
        end
      end
      ST_WAIT_REQ: begin
        if (pend_req_reg) begin
          state_next = ST_ARB;
        end
      end
      ST_ARB: begin
        state_next                        = ST_XFER;
        wb_valid_next                     = 1'b1;
        wb_word_next                      = word_reg;
        wb_word_next.item_count_minus_one = count;
      end
      ST_XFER: begin
        xfer_next = 1'b1;
        if (last) begin
          done_next = 1'b1;
          if (mode_reg == `DMTM_MODE_PING_PONG) begin
            state_next     = ST_FETCH;
            alt_next       = !alt_reg;
            fetch_req_next = 1'b1;
          end else begin
            state_next   = ST_IDLE;
            stopped_next = 1'b1;
            alt_next     = `DMTM_ALT_RST;
          end
        end else if (mode_reg == `DMTM_MODE_AUTO) begin
          state_next = ST_ARB;
        end else begin
          state_next = ST_WAIT_REQ;
        end
      end
      ST_SG: begin
        if (sg_done) begin
          state_next   = ST_IDLE;
          stopped_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      mode_reg     <= `DMTM_MODE_STOP;
      word_reg     <= '0;
      pend_req_reg <= 1'b0;
      alt_reg      <= `DMTM_ALT_RST;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      word_reg     <= word_next;
      pend_req_reg <= pend_req_next;
      alt_reg      <= alt_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_req_reg <= 1'b0;
      wb_valid_reg  <= 1'b0;
      wb_word_reg   <= '0;
      xfer_reg      <= 1'b0;
      done_reg      <= 1'b0;
      stopped_reg   <= `DMTM_STOPPED_RST;
      invalid_reg   <= 1'b0;
      sg_start_reg  <= 1'b0;
    end else begin
      fetch_req_reg <= fetch_req_next;
      wb_valid_reg  <= wb_valid_next;
      wb_word_reg   <= wb_word_next;
      xfer_reg      <= xfer_next;
      done_reg      <= done_next;
      stopped_reg   <= stopped_next;
      invalid_reg   <= invalid_next;
      sg_start_reg  <= sg_start_next;
    end
  end

  assign fetch_req    = fetch_req_reg;
  assign fetch_alt    = alt_reg;
  assign wb_valid     = wb_valid_reg;
  assign wb_word      = wb_word_reg;
  assign xfer_pulse   = xfer_reg;
  assign cycle_done   = done_reg;
  assign chan_stopped = stopped_reg;
  assign invalid_cfg  = invalid_reg;
  assign sg_start     = sg_start_reg;

  // Checks
  property p_stop_mode;
    @(posedge ref_clk) disable iff (rst)
    (fetched && f_stop) |=> (state_reg == ST_IDLE) && invalid_cfg && chan_stopped && !xfer_pulse;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop mode did not stop");

  property p_basic_req;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_ARB && mode_reg == `DMTM_MODE_BASIC) |-> $past(pend_req_reg);
  endproperty
  a_basic_req: assert property (p_basic_req) else $error("basic arb without request");

  property p_auto_run;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_XFER && !last && mode_reg == `DMTM_MODE_AUTO)
      |=> xfer_pulse && (state_reg == ST_ARB) ##1 (state_reg == ST_XFER) && wb_valid;
  endproperty
  a_auto_run: assert property (p_auto_run) else $error("auto mode stalled for request");

  property p_ping_alt;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_XFER && last && mode_reg == `DMTM_MODE_PING_PONG)
      |=> (state_reg == ST_FETCH) && fetch_req && (fetch_alt != $past(fetch_alt)) && cycle_done;
  endproperty
  a_ping_alt: assert property (p_ping_alt) else $error("ping-pong did not switch");

  property p_ping_end;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_XFER && last && mode_reg != `DMTM_MODE_PING_PONG)
      |=> (state_reg == ST_IDLE) && chan_stopped && cycle_done;
  endproperty
  a_ping_end: assert property (p_ping_end) else $error("non ping-pong cycle did not end");

  property p_wb_count;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_ARB)
      |=> wb_valid && (wb_word.item_count_minus_one == $past(count)) ##1 xfer_pulse;
  endproperty
  a_wb_count: assert property (p_wb_count) else $error("count not written before transfer");

  property p_count_dec;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_XFER && !last) |=> (count == $past(count) - CW'(1));
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count did not decrement");

  property p_sg_handoff;
    @(posedge ref_clk) disable iff (rst)
    (fetched && f_sg) |=> sg_start && (state_reg == ST_SG) ##1 !sg_start && !xfer_pulse;
  endproperty
  a_sg_handoff: assert property (p_sg_handoff) else $error("scatter-gather not handed off");

  property p_xfer_cause;
    @(posedge ref_clk) disable iff (rst)
    xfer_pulse |-> $past(state_reg == ST_XFER) && $past(state_reg == ST_ARB, 2);
  endproperty
  a_xfer_cause: assert property (p_xfer_cause) else $error("transfer without arbitration");

endmodule

// file: sim/dmtm_host_model.sv
// Control structure memory and host side of the channel
`timescale 1ns/1ns
module dmtm_host_model
  import dmtm_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           fetch_req,
  input  wire logic           fetch_alt,
  output logic                fetch_valid,
  output dmtm_ctl_word_t      fetch_word,
  input  wire logic           wb_valid,
  input  wire dmtm_ctl_word_t wb_word
);
  dmtm_ctl_word_t mem [2];
  int             lat = 0;
  int             wait_cnt;
  logic           served;

  initial mem = '{default: '0};
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'b0;
      fetch_word  <= '0;
      served      <= 1'b0;
      wait_cnt    <= 0;
    end else begin
      fetch_valid <= 1'b0;
      fetch_word  <= ~fetch_word;
      if (!fetch_req) begin
        served   <= 1'b0;
        wait_cnt <= 0;
      end else if (!served && wait_cnt >= lat) begin
        fetch_valid <= 1'b1;
        fetch_word  <= mem[fetch_alt];
        served      <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
      if (wb_valid) begin
        mem[fetch_alt] <= wb_word;
      end
    end
  end
endmodule

// file: sim/test_dma_channel_transfer_mode_control.sv
// Testbench for the transfer mode controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_dma_channel_transfer_mode_control
  import dmtm_pkg::*;
;
  logic ref_clk = 1'b0, rst = 1'b1, chan_enable = 1'b0, chan_request = 1'b0, sg_done = 1'b0;
  logic fetch_req, fetch_alt, fetch_valid, wb_valid, xfer_pulse, cycle_done;
  logic chan_stopped, invalid_cfg, sg_start;
  dmtm_ctl_word_t fetch_word, wb_word;
  int   n_mismatch = 0, checks_done = 0;
  int   n_xfer, n_wb, n_done, n_inv, n_sg;
  logic [9:0] last_wb;
  logic [2:0] alt_seq;

  always #5 ref_clk = ~ref_clk;

  dmtm_mode_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .chan_enable(chan_enable),
    .chan_request(chan_request), .fetch_req(fetch_req), .fetch_alt(fetch_alt),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .wb_valid(wb_valid),
    .wb_word(wb_word), .xfer_pulse(xfer_pulse), .cycle_done(cycle_done),
    .chan_stopped(chan_stopped), .invalid_cfg(invalid_cfg), .sg_start(sg_start),
    .sg_done(sg_done));
  dmtm_host_model HOST (.ref_clk(ref_clk), .rst(rst), .fetch_req(fetch_req),
    .fetch_alt(fetch_alt), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .wb_valid(wb_valid), .wb_word(wb_word));

  always @(posedge ref_clk) begin
    if (xfer_pulse === 1'b1) n_xfer++;
    if (cycle_done === 1'b1) n_done++;
    if (invalid_cfg === 1'b1) n_inv++;
    if (sg_start === 1'b1) n_sg++;
    if (fetch_valid === 1'b1) alt_seq = {alt_seq[1:0], fetch_alt};
    if (wb_valid === 1'b1) begin
      n_wb++;
      last_wb = wb_word.item_count_minus_one;
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic req;
    chan_request <= 1'b1;
    tick(1);
    chan_request <= 1'b0;
  endtask

  task automatic start(input logic [2:0] mp, input logic [9:0] np,
                       input logic [2:0] ma, input logic [9:0] na);
    int i;
    {n_xfer, n_wb, n_done, n_inv, n_sg} = '0;
    alt_seq = 3'h0;
    HOST.mem[0] = '{np, 1'b0, mp};
    HOST.mem[1] = '{na, 1'b0, ma};
    chan_enable <= 1'b1;
    i = 0;
    while (fetch_req !== 1'b1 && i < 50) begin
      tick(1);
      i++;
    end
    chan_enable <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wait_stop;
    int i;
    i = 0;
    while (chan_stopped !== 1'b1 && i < 300) begin
      tick(1);
      i++;
    end
    if (i == 300) begin
      n_mismatch++;
      end_sim();
    end
    tick(3);
  endtask

  task automatic t_invalid;
    logic [2:0] modes [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
    foreach (modes[k]) begin
      start(modes[k], 10'h003, 3'h0, 10'h000);
      wait_stop();
      `CHK("inv", 1, n_inv)
      `CHK("xfer", 0, n_xfer)
    end
  endtask

  task automatic t_basic;
    start(3'h1, 10'h001, 3'h0, 10'h000);
    tick(12);
    `CHK("no_req", 0, n_xfer)
    req();
    tick(8);
    `CHK("one", 1, n_xfer)
    `CHK("wb1", 10'h001, last_wb)
    req();
    wait_stop();
    `CHK("two", 2, n_xfer)
    `CHK("done", 1, n_done)
    `CHK("wb0", 10'h000, last_wb)
  endtask

  task automatic t_auto;
    start(3'h2, 10'h003, 3'h0, 10'h000);
    req();
    wait_stop();
    `CHK("items", 4, n_xfer)
    `CHK("wbs", 4, n_wb)
    `CHK("wbl", 10'h000, last_wb)
  endtask

  task automatic t_ping;
    HOST.lat = 3;
    start(3'h3, 10'h000, 3'h3, 10'h000);
    for (int k = 0; k < 3; k++) begin
      req();
      tick(14);
      if (k == 0) HOST.mem[0].transfer_mode_field = 3'h1;
    end
    wait_stop();
    `CHK("pp_items", 3, n_xfer)
    `CHK("pp_seq", 3'h2, alt_seq)
    `CHK("pp_done", 3, n_done)
    start(3'h3, 10'h000, 3'h0, 10'h000);
    req();
    wait_stop();
    `CHK("pp_inv", 1, n_inv)
    `CHK("pp_one", 1, n_xfer)
    HOST.lat = 0;
  endtask

  task automatic t_sg;
    start(3'h4, 10'h002, 3'h4, 10'h002);
    tick(5);
    `CHK("sg", 1, n_sg)
    `CHK("sg_busy", 1'b0, chan_stopped)
    sg_done <= 1'b1;
    tick(1);
    sg_done <= 1'b0;
    wait_stop();
    `CHK("sg_xfer", 0, n_xfer)
  endtask

  initial begin
    tick(3);
    rst <= 1'b0;
    tick(2);
    `CHK("stop_rst", 1'b1, chan_stopped)
    `CHK("freq_rst", 1'b0, fetch_req)
    t_invalid();
    t_basic();
    t_auto();
    t_ping();
    t_sg();
    end_sim();
  end
endmodule
